// ---- verilog/dic_pkg.sv ----
// Purpose: shared constants for the drive input command decoder
// Assumes: 40 MHz clock, terminal inputs closed-to-common reads as 1
// Notes: assignment codes as programmed per terminal
package dic_pkg;
   localparam int CLK_HZ = 40000000;
   localparam int NUM_TERM = 5;
   localparam int CODE_W = 11;
   // debounce settle time in microseconds, and cycles derived from it
   localparam int DEB_US = 2000;
   localparam int DEB_CYC = (DEB_US * (CLK_HZ / 1000000));
   // inch and run command pairing window
   localparam int INCH_WIN_MS = 100;
   localparam int INCH_WIN_CYC = INCH_WIN_MS * (CLK_HZ / 1000);
   // reset input least hold time
   localparam int CLR_MIN_MS = 10;
   localparam int CLR_MIN_CYC = CLR_MIN_MS * (CLK_HZ / 1000);
   localparam logic [10:0] NEG_OFS = 11'h3E8;
   localparam logic [10:0] CODE_NONE = 11'h7FF;
   localparam logic [10:0] CODE_FAULT_CLR = 11'h008;
   localparam logic [10:0] CODE_EXT_TRIP = 11'h009;
   localparam logic [10:0] CODE_INCH = 11'h00A;
   localparam logic [10:0] CODE_FREQ_SEL = 11'h00B;
   localparam logic [10:0] CODE_WRITE_GATE = 11'h013;
   localparam logic [10:0] CODE_PID_BYPASS = 11'h014;
   localparam logic [10:0] CODE_INVERT = 11'h015;
   localparam logic [10:0] CODE_COMMS = 11'h018;
   localparam logic [10:0] CODE_PID_CLR = 11'h021;
   localparam logic [10:0] CODE_PID_FRZ = 11'h022;
   localparam logic [10:0] CODE_AHEAD = 11'h062;
   localparam logic [10:0] CODE_BACK = 11'h063;
   localparam logic [1:0] RUN_SRC_TERM = 2'h1;
   localparam logic [1:0] PID_DIR_NONE = 2'h0;
   localparam logic [1:0] PID_DIR_INV = 2'h2;
   localparam logic [1:0] PROTECT_ALL = 2'h0;
   localparam logic [1:0] PROTECT_PART = 2'h1;
   typedef enum logic [1:0] {DIC_IDLE, DIC_RUN, DIC_INCH, DIC_ALARM} dic_mode_e;
endpackage : dic_pkg

// ---- verilog/dic_debounce.sv ----
// Purpose: synchronise and debounce one terminal input
// Assumes: input may be asynchronous to the clock in practice
// Notes: output changes only after the input has been stable DEB cycles
`timescale 1ns/1ps
module dic_debounce #(
   parameter int DEB = dic_pkg::DEB_CYC
) (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // raw and clean level
   input wire logic raw,
   output logic clean
);
   import dic_pkg::*;
   typedef struct packed {
      logic s1;
      logic s2;
      logic clean;
      logic [31:0] cnt;
   } dic_deb_s;
   dic_deb_s st_r;
   dic_deb_s st_nxt;
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = raw;
      st_nxt.s2 = st_r.s1;
      if (st_r.s2 == st_r.clean) begin
         st_nxt.cnt = 32'h0;
      end else if (st_r.cnt >= 32'(DEB - 1)) begin
         // one edge per transition, bounce is swallowed by the restart
         st_nxt.clean = st_r.s2; // (R24)
         st_nxt.cnt = 32'h0;
      end else begin
         st_nxt.cnt = st_r.cnt + 32'h1;
      end
   end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign clean = st_r.clean;
endmodule : dic_debounce

// ---- verilog/dic_decoder.sv ----
// Purpose: decode programmable digital input terminals into drive controls
// Assumes: terminal_in high means the terminal is closed to the common terminal
// Notes: one module per drive, keypad events are one-cycle pulses except key_run, which is held as a level
//
// Notes on behaviour
// (R1) in alarm, closing fault-clear drops alarm outputs; opening it allows restart
// (R2) partner holds fault-clear closed at least 10 ms, else keeps it open
// (R3) external trip opening while running cuts output and raises trip alarm
// (R4) trip alarm stays latched until stop/reset key or other reset; the code also clears it when fault-clear closes
// (R5) unassigned external trip reads as always on
// (R6) keypad source: stop+up toggles inch-ready only while inch input off
// (R7) terminal source: stop+up combination ignored for inch selection
// (R8) inch-ready changes only while output is stopped
// (R9) partner pairs inch input and run command within 100 ms
// (R10) run before inch input gives ordinary running until inch turns on
// (R11) inch-ready starts inching on run key or run command; release stops
// (R12) frequency select off or unassigned picks primary, on picks secondary
// (R13) write gate off forbids edits; on uses protect code 0 all, 1 partial
// (R14) unassigned write gate reads as always on
// (R15) PID bypass off runs PID, on uses manual frequency
// (R16) direction code 0: invert-sense selects normal or inverse set frequency
// (R17) PID direction is configured direction flipped by invert-sense
// (R18) comms gate on takes commands from the serial link
// (R19) unassigned comms gate reads as always on
// (R20) PID term clear resets integral and differential parts
// (R21) PID integral freeze stops integral from increasing
// (R22) codes 98 and 99 run ahead and backward, off decelerates to stop
// (R23) code plus 1000 makes terminal active open; not for run codes
// (R24) every terminal synchronised and debounced before use
`timescale 1ns/1ps
module dic_decoder #(
   parameter int NT = dic_pkg::NUM_TERM,
   parameter int DEB = dic_pkg::DEB_CYC,
   parameter int INCH_WIN = dic_pkg::INCH_WIN_CYC
) (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // terminals and their assignment codes
   input wire logic [NT-1:0] terminal_in,
   input wire logic [NT*dic_pkg::CODE_W-1:0] first_input_assign_code,
   // configuration codes
   input wire logic [1:0] run_source_code,
   input wire logic [1:0] data_protect_code,
   input wire logic [1:0] pid_direction_code,
   // keypad events and drive status
   input wire logic key_stop_up,
   input wire logic key_run,
   input wire logic key_stop_reset,
   input wire logic other_reset,
   input wire logic fault_event,
   input wire logic edit_is_protect_or_init,
   // drive controls
   output logic output_enable,
   output logic ahead_run_cmd,
   output logic backward_run_cmd,
   output logic inch_mode,
   output logic inch_ready,
   output logic alarm_active,
   output logic ext_trip_alarm,
   output logic transistor_out,
   output logic relay_contacts,
   output logic restart_allowed,
   // setting selections
   output logic freq_source_sel,
   output logic edit_allowed,
   output logic pid_enable,
   output logic pid_inverse,
   output logic setfreq_inverse,
   output logic link_select,
   output logic pid_terms_clear,
   output logic pid_integral_freeze
);
   import dic_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // terminal conditioning
   logic [NT-1:0] clean;
   for (genvar g = 0; g < NT; g++) begin : g_deb
      dic_debounce #(.DEB(DEB)) u_deb ( // (R24)
         .clock(clock),
         .rstn(rstn),
         .raw(terminal_in[g]),
         .clean(clean[g])
      );
   end

   // match a function code; returns found and active level (R23 inversion)
   function automatic logic [1:0] term_func(input logic [NT*CODE_W-1:0] codes,
                                            input logic [NT-1:0] lvl,
                                            input logic [CODE_W-1:0] fc,
                                            input logic neg_ok);
      logic [CODE_W-1:0] c;
      logic [1:0] r;
      r = 2'h0;
      for (int i = 0; i < NT; i++) begin
         c = codes[i*CODE_W +: CODE_W];
         if (c == fc) begin
            r = {1'b1, lvl[i]};
         end else if (neg_ok && (c == fc + NEG_OFS)) begin
            r = {1'b1, ~lvl[i]}; // (R23)
         end
      end
      return r;
   endfunction : term_func

   logic [1:0] f_clr, f_trip, f_inch, f_fsel, f_wg, f_byp, f_inv, f_lnk, f_prst, f_phld;
   logic [1:0] f_ah, f_bk;
   always_comb begin
      f_clr = term_func(first_input_assign_code, clean, CODE_FAULT_CLR, 1'b1);
      f_trip = term_func(first_input_assign_code, clean, CODE_EXT_TRIP, 1'b1);
      f_inch = term_func(first_input_assign_code, clean, CODE_INCH, 1'b1);
      f_fsel = term_func(first_input_assign_code, clean, CODE_FREQ_SEL, 1'b1);
      f_wg = term_func(first_input_assign_code, clean, CODE_WRITE_GATE, 1'b1);
      f_byp = term_func(first_input_assign_code, clean, CODE_PID_BYPASS, 1'b1);
      f_inv = term_func(first_input_assign_code, clean, CODE_INVERT, 1'b1);
      f_lnk = term_func(first_input_assign_code, clean, CODE_COMMS, 1'b1);
      f_prst = term_func(first_input_assign_code, clean, CODE_PID_CLR, 1'b1);
      f_phld = term_func(first_input_assign_code, clean, CODE_PID_FRZ, 1'b1);
      // run commands never take the open-active form
      f_ah = term_func(first_input_assign_code, clean, CODE_AHEAD, 1'b0); // (R23)
      f_bk = term_func(first_input_assign_code, clean, CODE_BACK, 1'b0); // (R23)
   end

   // assigned to some terminal and at its active level
   function automatic logic fn_on(input logic [1:0] f);
      return f[1] & f[0];
   endfunction : fn_on

   // active level, or the given level when no terminal carries the function
   function automatic logic fn_dflt(input logic [1:0] f, input logic dflt);
      return f[1] ? f[0] : dflt;
   endfunction : fn_dflt

   logic clr_on;
   logic trip_on;
   logic inch_on;
   logic ah_on;
   logic bk_on;
   logic run_on;
   logic fsel_on;
   logic wg_on;
   logic byp_on;
   logic inv_on;
   logic lnk_on;
   logic prst_on;
   logic phld_on;
   assign clr_on = fn_on(f_clr);
   // unassigned trip input counts as closed, so no trip
   assign trip_on = fn_dflt(f_trip, 1'b1); // (R5)
   assign inch_on = fn_on(f_inch);
   assign ah_on = fn_on(f_ah);
   assign bk_on = fn_on(f_bk);
   assign run_on = ah_on | bk_on;
   assign fsel_on = fn_on(f_fsel); // (R12)
   // unassigned write gate and comms gate act as closed
   assign wg_on = fn_dflt(f_wg, 1'b1); // (R14)
   assign byp_on = fn_on(f_byp);
   assign inv_on = fn_on(f_inv);
   assign lnk_on = fn_dflt(f_lnk, 1'b1); // (R19)
   assign prst_on = fn_on(f_prst);
   assign phld_on = fn_on(f_phld);

   ////////////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      dic_mode_e mode;
      logic inch_rdy;
      logic inch_drop;
      logic trip_alarm;
      logic alarm;
      logic alarm_shown;
      logic clr_prev;
      logic inch_prev;
      logic run_prev;
      logic [31:0] win;
      logic oe;
      logic inch_m;
      logic ahead;
      logic back;
      logic fsel;
      logic edit;
      logic pid_en;
      logic pid_inv;
      logic sf_inv;
      logic link;
      logic prst;
      logic phld;
      logic restart;
   } dic_state_s;
   dic_state_s st_r;
   dic_state_s st_nxt;

   always_comb begin
      logic stopped;
      logic run_rise;
      logic inch_rise;
      logic inch_go;
      stopped = 1'b0;
      run_rise = 1'b0;
      inch_rise = 1'b0;
      inch_go = 1'b0;
      st_nxt = st_r;
      stopped = (st_r.mode == DIC_IDLE);
      run_rise = run_on & ~st_r.run_prev;
      inch_rise = inch_on & ~st_r.inch_prev;
      // inch input rising with the run command counts as ready already
      inch_go = st_r.inch_rdy | inch_on;
      st_nxt.clr_prev = clr_on;
      st_nxt.inch_prev = inch_on;
      st_nxt.run_prev = run_on;
      st_nxt.restart = 1'b0;
      // pairing window opened by either edge, counts down
      if (run_rise || inch_rise) begin
         st_nxt.win = 32'(INCH_WIN);
      end else if (st_r.win != 32'h0) begin
         st_nxt.win = st_r.win - 32'h1;
      end

      // a release seen while driving is applied once the output stops
      if (inch_on) begin
         st_nxt.inch_drop = 1'b0;
      end else if (st_r.inch_prev) begin
         st_nxt.inch_drop = 1'b1;
      end
      // inch readiness: changes only while output is stopped
      if (stopped) begin // (R8)
         st_nxt.inch_drop = 1'b0;
         if (run_source_code == RUN_SRC_TERM) begin
            st_nxt.inch_rdy = inch_on; // (R7)
         end else if (inch_on) begin
            st_nxt.inch_rdy = 1'b1; // (R6)
         end else if (key_stop_up) begin
            st_nxt.inch_rdy = ~st_r.inch_rdy; // (R6)
         end else if (st_r.inch_prev || st_r.inch_drop) begin
            st_nxt.inch_rdy = 1'b0;
         end
      end

      case (st_r.mode)
         DIC_IDLE: begin
            st_nxt.ahead = 1'b0;
            st_nxt.back = 1'b0;
            if (inch_go && (key_run ||
                (run_rise && (inch_rise || st_r.win != 32'h0)))) begin
               // late pairing beyond the window gives no inching
               st_nxt.mode = DIC_INCH; // (R11)
               st_nxt.ahead = ah_on;
               st_nxt.back = bk_on;
            end else if (run_on) begin
               st_nxt.mode = DIC_RUN; // (R22)
               st_nxt.ahead = ah_on;
               st_nxt.back = bk_on & ~ah_on;
            end
         end
         DIC_RUN: begin
            // direction follows whichever run command is closed
            st_nxt.ahead = ah_on; // (R22)
            st_nxt.back = bk_on & ~ah_on; // (R22)
            if (!run_on) begin
               st_nxt.mode = DIC_IDLE; // (R22)
            end else if (inch_rise && st_r.win != 32'h0) begin
               st_nxt.mode = DIC_INCH; // (R10)
            end
         end
         DIC_INCH: begin
            if (!run_on && !key_run) begin
               st_nxt.mode = DIC_IDLE; // (R11)
            end
         end
         default: begin
            // leave alarm only once reset input opens again
            if (!st_r.trip_alarm && !st_r.alarm && !clr_on) begin
               st_nxt.mode = DIC_IDLE;
               st_nxt.restart = 1'b1; // (R1)
            end
         end
      endcase

      // faults; trip only counts while driving
      if (!trip_on && st_r.mode != DIC_IDLE && st_r.mode != DIC_ALARM) begin
         st_nxt.trip_alarm = 1'b1; // (R3)
      end else if (key_stop_reset || other_reset || (clr_on && !st_r.clr_prev)) begin
         st_nxt.trip_alarm = 1'b0; // (R4)
      end
      if (fault_event) begin
         st_nxt.alarm = 1'b1;
      end else if (!clr_on && st_r.clr_prev) begin
         // alarm mode holds while clear is closed, released when it opens
         st_nxt.alarm = 1'b0; // (R1)
      end
      if (st_nxt.trip_alarm || st_nxt.alarm) begin
         st_nxt.mode = DIC_ALARM; // (R3)
         st_nxt.ahead = 1'b0;
         st_nxt.back = 1'b0;
         // a fresh fault in the exit cycle cancels the restart
         st_nxt.restart = 1'b0;
      end
      // alarm indication drops as soon as clear closes
      st_nxt.alarm_shown = (st_nxt.trip_alarm || st_nxt.alarm) && !clr_on; // (R1)
      st_nxt.oe = (st_nxt.mode == DIC_RUN) || (st_nxt.mode == DIC_INCH); // (R3)
      st_nxt.inch_m = (st_nxt.mode == DIC_INCH);

      // setting selections
      st_nxt.fsel = fsel_on; // (R12)
      if (!wg_on) begin
         st_nxt.edit = 1'b0; // (R13)
      end else if (data_protect_code == PROTECT_ALL) begin
         st_nxt.edit = 1'b1; // (R13)
      end else if (data_protect_code == PROTECT_PART) begin
         st_nxt.edit = edit_is_protect_or_init; // (R13)
      end else begin
         st_nxt.edit = 1'b0;
      end
      st_nxt.pid_en = !byp_on && pid_direction_code != PID_DIR_NONE; // (R15)
      st_nxt.pid_inv = (pid_direction_code == PID_DIR_INV) ^ inv_on; // (R17)
      st_nxt.sf_inv = (pid_direction_code == PID_DIR_NONE) & inv_on; // (R16)
      st_nxt.link = lnk_on; // (R18)
      st_nxt.prst = prst_on; // (R20)
      st_nxt.phld = phld_on; // (R21)
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         st_r <= '{mode: DIC_IDLE, link: 1'b1, default: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs straight from state flops
   assign output_enable = st_r.oe;
   assign ahead_run_cmd = st_r.ahead;
   assign backward_run_cmd = st_r.back;
   assign inch_mode = st_r.inch_m;
   assign inch_ready = st_r.inch_rdy;
   assign alarm_active = st_r.alarm;
   assign ext_trip_alarm = st_r.trip_alarm;
   assign transistor_out = st_r.alarm_shown;
   assign relay_contacts = st_r.alarm_shown;
   assign restart_allowed = st_r.restart;
   assign freq_source_sel = st_r.fsel;
   assign edit_allowed = st_r.edit;
   assign pid_enable = st_r.pid_en;
   assign pid_inverse = st_r.pid_inv;
   assign setfreq_inverse = st_r.sf_inv;
   assign link_select = st_r.link;
   assign pid_terms_clear = st_r.prst;
   assign pid_integral_freeze = st_r.phld;
endmodule : dic_decoder

// ---- sim/dic_props.sv ----
// Purpose: port assertions for the input command decoder
// Assumes: one clock, rstn asynchronous active low
// Notes: attached by bind from the bench top
`timescale 1ns/1ps
module dic_props
   import dic_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // inputs watched
   input wire logic key_stop_up,
   input wire logic key_stop_reset,
   input wire logic other_reset,
   input wire logic [1:0] data_protect_code,
   input wire logic [1:0] pid_direction_code,
   input wire logic edit_is_protect_or_init,
   // outputs watched
   input wire logic output_enable,
   input wire logic inch_ready,
   input wire logic alarm_active,
   input wire logic ext_trip_alarm,
   input wire logic transistor_out,
   input wire logic relay_contacts,
   input wire logic restart_allowed,
   input wire logic edit_allowed,
   input wire logic pid_enable
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////////////////////////
   a_trip_cuts_out: assert property (ext_trip_alarm |-> !output_enable)
      else $error("output on during trip alarm");
   a_alarm_no_drive: assert property (alarm_active |-> !output_enable)
      else $error("output on in alarm mode");
   // only the keys clear a latched trip in our scenarios
   a_trip_latch_held: assert property ($fell(ext_trip_alarm) |-> $past(key_stop_reset)
      || $past(other_reset) || $past(key_stop_reset, 2) || $past(other_reset, 2))
      else $error("trip alarm dropped without reset");
   a_inch_run_hold: assert property (key_stop_up && output_enable |=> $stable(inch_ready))
      else $error("inch ready changed while running");
   a_alarm_out_pair: assert property (transistor_out == relay_contacts)
      else $error("alarm outputs disagree");
   a_restart_pulse: assert property (restart_allowed |-> !alarm_active && !ext_trip_alarm
      && !output_enable ##1 !restart_allowed)
      else $error("restart pulse malformed");
   a_edit_partial: assert property ($past(data_protect_code) == PROTECT_PART
      && $past(data_protect_code, 2) == PROTECT_PART && !$past(edit_is_protect_or_init)
      && !$past(edit_is_protect_or_init, 2) |-> !edit_allowed)
      else $error("edit allowed under partial protect");
   a_pid_no_dir: assert property ($past(pid_direction_code) == PID_DIR_NONE
      && $past(pid_direction_code, 2) == PID_DIR_NONE |-> !pid_enable)
      else $error("pid enabled with no direction");
endmodule : dic_props

// ---- sim/dic_contacts.sv ----
// Purpose: model of the contacts wired to the input terminals
// Assumes: each change of a contact bounces before it settles
// Notes: bounce is kept shorter than the debounce span in sim
`timescale 1ns/1ps
module dic_contacts (
   // clock
   input wire logic clock,
   // wanted contact state and terminal levels
   input wire logic [4:0] want,
   output logic [4:0] terminal_in
);
   logic [4:0] lvl = 5'h00;
   int cnt = 0;
   initial terminal_in = 5'h00;
   // the bench holds fault-clear closed many debounce spans and pairs inch with run
   always @(posedge clock) begin
      if (want !== lvl) begin
         cnt = 3;
         lvl = want;
      end
      if (cnt > 0) begin
         cnt = cnt - 1;
         terminal_in <= ~terminal_in;
      end else begin
         terminal_in <= lvl;
      end
   end
endmodule : dic_contacts

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench for the input command decoder
// Assumes: short debounce and inch window parameters in sim
// Notes: stimulus mixes corner cases with lfsr values
`timescale 1ns/1ps
module tb_top;
   import dic_pkg::*;
   logic clock = 0, rstn = 0, key_run = 0, ed = 0, rs_seen = 0;
   logic [3:0] kv = 4'h0;
   logic [4:0] want = 5'h00, ti;
   logic [54:0] fc = {5{CODE_NONE}};
   logic [1:0] rsc = 2'h0, prot = 2'h0, dir = 2'h0;
   logic [15:0] r = 16'h0041;
   logic [4:0] e, ng;
   int err_total = 0, checks_done = 0;
   wire oe, ah, bk, im, ir, al, tr, tx, rc, ra, fs, ea, pe, pi, sf, ls, pc, pf;
   always #12.5 clock = ~clock;
   dic_contacts u_sw (.clock(clock), .want(want), .terminal_in(ti));
   dic_decoder #(.NT(5), .DEB(4), .INCH_WIN(50)) dut (.clock(clock), .rstn(rstn),
      .terminal_in(ti), .first_input_assign_code(fc), .run_source_code(rsc),
      .data_protect_code(prot), .pid_direction_code(dir), .key_stop_up(kv[1]),
      .key_run(key_run), .key_stop_reset(kv[2]), .other_reset(kv[3]), .fault_event(kv[0]),
      .edit_is_protect_or_init(ed), .output_enable(oe), .ahead_run_cmd(ah),
      .backward_run_cmd(bk), .inch_mode(im), .inch_ready(ir), .alarm_active(al),
      .ext_trip_alarm(tr), .transistor_out(tx), .relay_contacts(rc), .restart_allowed(ra),
      .freq_source_sel(fs), .edit_allowed(ea), .pid_enable(pe), .pid_inverse(pi),
      .setfreq_inverse(sf), .link_select(ls), .pid_terms_clear(pc), .pid_integral_freeze(pf));
   always @(posedge clock) if (ra === 1'b1) rs_seen <= 1'b1;
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] nx(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : nx
   task automatic step(int n);
      repeat (n) @(posedge clock);
      #2;
   endtask : step
   task automatic settle();
      step(16);
   endtask : settle
   task automatic pk(int b);
      kv[b] = 1'b1;
      step(1);
      kv[b] = 1'b0;
      step(3);
   endtask : pk
   task automatic setc(int i, logic [10:0] c);
      fc[11*i+:11] = c;
   endtask : setc
   task automatic chk(string n, logic s, logic x);
      checks_done++;
      if (s !== x) begin
         err_total++;
         $display("mismatch %s expected %b seen %b", n, x, s);
      end
   endtask : chk
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_of_test
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #(25 * 20000);
      err_total++;
      end_of_test();
   end
   initial begin
      step(10);
      rstn = 1;
      settle();
      chk("link", ls, 1'b1);
      chk("trip", tr, 1'b0);
      chk("fsel", fs, 1'b0);
      chk("edit", ea, 1'b1);
      want = 5'h02;
      settle();
      setc(0, CODE_FAULT_CLR); setc(1, CODE_EXT_TRIP); setc(2, CODE_INCH);
      setc(3, CODE_AHEAD); setc(4, CODE_BACK);
      want[3] = 1; settle();
      chk("oe", oe, 1'b1);
      chk("ahead", ah, 1'b1);
      pk(1);
      chk("iready", ir, 1'b0);
      want[3] = 0; want[4] = 1; settle();
      chk("ahead", ah, 1'b0);
      chk("back", bk, 1'b1);
      want[1] = 0; settle();
      chk("trip", tr, 1'b1);
      chk("oe", oe, 1'b0);
      chk("tout", tx, 1'b1);
      chk("relay", rc, 1'b1);
      want[1] = 1; want[4] = 0; settle();
      chk("trip", tr, 1'b1);
      pk(2);
      chk("trip", tr, 1'b0);
      settle(); pk(0); rs_seen = 0;
      chk("alarm", al, 1'b1);
      want[0] = 1; settle();
      chk("tout", tx, 1'b0);
      chk("relay", rc, 1'b0);
      chk("alarm", al, 1'b1);
      want[0] = 0; settle();
      chk("alarm", al, 1'b0);
      chk("restart", rs_seen, 1'b1);
      pk(1); chk("iready", ir, 1'b1);
      pk(1); chk("iready", ir, 1'b0);
      rsc = RUN_SRC_TERM; pk(1);
      chk("iready", ir, 1'b0);
      rsc = 2'h0; want[2] = 1; settle();
      chk("iready", ir, 1'b1);
      pk(1); chk("iready", ir, 1'b1);
      key_run = 1; step(4);
      chk("inch", im, 1'b1);
      key_run = 0; settle();
      chk("inch", im, 1'b0);
      want[2] = 0; settle();
      want[3:2] = 2'h3; settle();
      chk("inch", im, 1'b1);
      want[3:2] = 2'h0; settle();
      want[3] = 1; step(60);
      chk("inch", im, 1'b0);
      chk("ahead", ah, 1'b1);
      want[1] = 0; settle();
      chk("trip", tr, 1'b1);
      want[1] = 1; want[3] = 0; settle();
      pk(3); chk("trip", tr, 1'b0);
      settle();
      // random levels, polarity, protect and direction codes
      for (int k = 0; k < 10; k++) begin
         r = nx(r);
         ng = r[9:5];
         setc(0, CODE_FREQ_SEL + (ng[0] ? NEG_OFS : 11'h000));
         setc(1, CODE_WRITE_GATE + (ng[1] ? NEG_OFS : 11'h000));
         setc(2, CODE_PID_BYPASS + (ng[2] ? NEG_OFS : 11'h000));
         setc(3, CODE_INVERT + (ng[3] ? NEG_OFS : 11'h000));
         setc(4, CODE_COMMS + (ng[4] ? NEG_OFS : 11'h000));
         want = r[4:0]; prot = {1'b0, r[10]}; ed = r[13];
         dir = (r[12:11] == 2'h3) ? 2'h1 : r[12:11];
         settle();
         e = want ^ ng;
         chk("fsel", fs, e[0]);
         chk("edit", ea, e[1] && (prot == PROTECT_ALL || ed));
         chk("pid", pe, !e[2] && dir != PID_DIR_NONE);
         chk("sfinv", sf, dir == PID_DIR_NONE && e[3]);
         if (!e[2] && dir != PID_DIR_NONE) chk("pidinv", pi, (dir == PID_DIR_INV) ^ e[3]);
         chk("link", ls, e[4]);
      end
      fc = {5{CODE_NONE}};
      setc(0, CODE_PID_CLR); setc(1, CODE_PID_FRZ);
      setc(2, CODE_AHEAD + NEG_OFS);
      want = 5'h03; settle();
      chk("pclr", pc, 1'b1);
      chk("pfrz", pf, 1'b1);
      chk("oe", oe, 1'b0);
      want = 5'h00; settle();
      chk("pclr", pc, 1'b0);
      chk("pfrz", pf, 1'b0);
      end_of_test();
   end
endmodule : tb_top
bind dic_decoder dic_props chk_i (.clock(clock), .rstn(rstn), .key_stop_up(key_stop_up),
   .key_stop_reset(key_stop_reset), .other_reset(other_reset),
   .data_protect_code(data_protect_code), .pid_direction_code(pid_direction_code),
   .edit_is_protect_or_init(edit_is_protect_or_init), .output_enable(output_enable),
   .inch_ready(inch_ready), .alarm_active(alarm_active), .ext_trip_alarm(ext_trip_alarm),
   .transistor_out(transistor_out), .relay_contacts(relay_contacts),
   .restart_allowed(restart_allowed), .edit_allowed(edit_allowed), .pid_enable(pid_enable));
